// ---- csk_exec.sv ----
`timescale 1ns/1ps
`include "csk_defines.svh"

module csk_exec #(
  parameter int ADDR_W = 14,
  parameter int BSR_W = 6
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic start,
  input wire csk_pkg::csk_req_s req,
  input wire logic [7:0] rdata,
  output csk_pkg::csk_mem_s mem,
  output csk_pkg::csk_stat_s stat,
  output logic [1:0] q_phase
);
  import csk_pkg::*;

  // the two supported opcodes share one decode
  function automatic logic is_op(input logic [15:0] w, input logic [6:0] op);
    is_op = (w[15:`CSK_OPC_LSB] == op);
  endfunction : is_op

  function automatic logic is_cmp(input logic [15:0] w);
    is_cmp = is_op(w, `CSK_OPC_EQ) | is_op(w, `CSK_OPC_GT);
  endfunction : is_cmp

  csk_state_e state_reg;
  csk_state_e state_next;
  csk_req_s req_reg;
  logic [1:0] q_reg;
  logic [1:0] nop_left_reg;
  logic [1:0] nop_left_next;
  logic rd_en_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic skip_reg;
  logic skip_next;
  logic flush_reg;
  logic nop_reg;
  logic done_reg;
  logic busy_reg;

  wire [7:0] f_op = req_reg.instr[7:0];
  wire a_bit = req_reg.instr[`CSK_ABIT];
  wire low_half = (f_op <= `CSK_ACCESS_SPLIT);
  wire indexed = !a_bit && req_reg.ext_en && low_half;
  wire [ADDR_W-1:0] idx_addr =
    ADDR_W'(req_reg.index_base + {{(ADDR_W-8){1'b0}}, f_op});
  wire [ADDR_W-1:0] banked_addr =
    {req_reg.bank_select_register[BSR_W-1:0], f_op};
  // access bank: low part in bank 0, high part in the last bank
  wire [ADDR_W-1:0] access_addr =
    low_half ? {{BSR_W{1'b0}}, f_op} : {{BSR_W{1'b1}}, f_op};
  wire [ADDR_W-1:0] eff_addr =
    a_bit ? banked_addr :                            // [RULE4]
    indexed ? idx_addr :                             // [RULE5]
    access_addr;                                     // [RULE3]

  wire is_eq = is_op(req_reg.instr, `CSK_OPC_EQ);
  // unsigned difference; no status flag is ever written by this block
  wire [8:0] diff = {1'b0, rdata} - {1'b0, req_reg.working_register};
  wire hit_eq = (diff == 9'h000);                    // [RULE6]
  wire hit_gt = !diff[8] && (diff != 9'h000);        // [RULE7]
  wire cond = is_eq ? hit_eq : hit_gt;

  // a zero word count is treated as a one-word instruction
  wire [1:0] words = (req_reg.next_words == 2'h0) ? 2'h1 :
    req_reg.next_words;
  wire q_end = (q_reg == `CSK_Q_LAST);
  wire accept = start && is_cmp(req.instr);

  always_comb
  begin
    state_next = state_reg;
    nop_left_next = nop_left_reg;
    skip_next = skip_reg;
    case (state_reg)
      CSK_IDLE:
      begin
        if (accept)
        begin
          state_next = CSK_EXEC;
          skip_next = 1'b0;
        end
      end
      CSK_EXEC:
      begin
        if (q_reg == `CSK_Q_PROC)
        begin
          skip_next = cond;
        end
        if (q_end)
        begin
          if (skip_reg)
          begin
            // one extra cycle per word of the dropped instruction
            state_next = CSK_NOP;                    // [RULE1]
            nop_left_next = 2'(words - 2'h1);        // [RULE2]
          end
          else
          begin
            state_next = CSK_IDLE;
          end
        end
      end
      CSK_NOP:
      begin
        if (q_end)
        begin
          if (nop_left_reg == 2'h0)
          begin
            state_next = CSK_IDLE;
          end
          else
          begin
            nop_left_next = 2'(nop_left_reg - 2'h1); // [RULE2]
          end
        end
      end
      default:
      begin
        state_next = CSK_IDLE;
      end
    endcase
  end

  wire leaving = (state_next == CSK_IDLE) && (state_reg != CSK_IDLE);
  wire to_nop = (state_reg == CSK_EXEC) && (state_next == CSK_NOP);
  wire read_now = (state_reg == CSK_EXEC) && (q_reg == `CSK_Q_READ);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= CSK_IDLE;
      nop_left_reg <= 2'h0;
      skip_reg <= 1'b0;
    end
    else if (ce)
    begin
      state_reg <= state_next;
      nop_left_reg <= nop_left_next;
      skip_reg <= skip_next;
    end
  end

  // the quarter phase restarts at q1 whenever a new compare is taken
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      q_reg <= 2'h0;
    end
    else if (ce)
    begin
      if (state_reg == CSK_IDLE)
      begin
        q_reg <= 2'h0;
      end
      else
      begin
        q_reg <= 2'(q_reg + 2'h1);
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      req_reg <= '0;
    end
    else if (ce && accept && (state_reg == CSK_IDLE))
    begin
      req_reg <= req;
    end
  end

  // operand read goes out in q2; memory answers in q3
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_en_reg <= 1'b0;
      addr_reg <= ADDR_W'(`CSK_RST_ADDR);
    end
    else if (ce)
    begin
      rd_en_reg <= read_now;
      if (read_now)
      begin
        addr_reg <= eff_addr;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      flush_reg <= 1'b0;
      nop_reg <= 1'b0;
      done_reg <= 1'b0;
      busy_reg <= 1'b0;
    end
    else if (ce)
    begin
      flush_reg <= to_nop;                           // [RULE1]
      nop_reg <= (state_next == CSK_NOP);            // [RULE1]
      done_reg <= leaving;
      busy_reg <= (state_next != CSK_IDLE);
    end
  end

  // state outputs are registered copies so they line up with busy
  logic [1:0] q_out_reg;
  logic skip_out_reg;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      q_out_reg <= 2'h0;
      skip_out_reg <= 1'b0;
    end
    else if (ce)
    begin
      q_out_reg <= (state_next == CSK_IDLE) ? 2'h0 :
        ((state_reg == CSK_IDLE) ? 2'h0 : 2'(q_reg + 2'h1));
      skip_out_reg <= skip_next;
    end
  end

  assign mem.rd_en = rd_en_reg;
  assign mem.addr = addr_reg;
  assign stat.busy = busy_reg;
  assign stat.skip = skip_out_reg;
  assign stat.flush = flush_reg;
  assign stat.no_operation = nop_reg;
  assign stat.done = done_reg;
  assign q_phase = q_out_reg;

endmodule : csk_exec

// ---- csk_defines.svh ----
// Behaviour
// (RULE1) a true compare drops the fetched instruction and runs a no_operation
// (RULE2) skipping a two-word instruction costs three cycles, three-word four
// (RULE3) bank bit clear: operand lies in the access bank, bank select ignored
// (RULE4) bank bit set: bank_select_register picks the register bank
// (RULE5) bank bit clear, extended set on, operand up to 5fh: indexed offset
// (RULE6) equal skip: unsigned operand minus working_register, flags untouched
// (RULE7) greater skip: skip only if operand strictly larger, flags untouched
`ifndef CSK_DEFINES_SVH
`define CSK_DEFINES_SVH

`define CSK_OPC_EQ 7'h31
`define CSK_OPC_GT 7'h32
`define CSK_OPC_LSB 9
`define CSK_ABIT 8
`define CSK_ACCESS_SPLIT 8'h5f
`define CSK_Q_LAST 2'h3
`define CSK_Q_READ 2'h0
`define CSK_Q_PROC 2'h2
`define CSK_BASE_CYCLES 1
`define CSK_RST_ADDR 14'h0000

`endif

// ---- csk_pkg.sv ----
package csk_pkg;

  typedef enum logic [1:0]
  {
    CSK_IDLE,
    CSK_EXEC,
    CSK_NOP
  } csk_state_e;

  typedef struct packed {
    logic [15:0] instr;
    logic [7:0] working_register;
    logic [5:0] bank_select_register;
    logic ext_en;
    logic [13:0] index_base;
    logic [1:0] next_words;
  } csk_req_s;

  typedef struct packed {
    logic rd_en;
    logic [13:0] addr;
  } csk_mem_s;

  typedef struct packed {
    logic busy;
    logic skip;
    logic flush;
    logic no_operation;
    logic done;
  } csk_stat_s;

endpackage : csk_pkg

// ---- csk_monitor.sv ----
`timescale 1ns/1ps
module csk_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic start,
  input wire csk_pkg::csk_req_s req,
  input wire logic [7:0] rdata,
  input wire csk_pkg::csk_mem_s mem,
  input wire csk_pkg::csk_stat_s stat,
  input wire logic [1:0] q_phase
);
  import csk_pkg::*;
  wire [7:0] f = req.instr[7:0];
  wire [6:0] op = req.instr[15:9];
  wire lo = f <= 8'h5f;
  // result cycle: last quarter of the compare, before any no_operation
  wire res = stat.busy && q_phase == 2'h3 && !stat.no_operation;
  default clocking cb @(posedge clk);
  endclocking
  // ce low freezes the core, so checks in flight are abandoned while it is low
  default disable iff (rst || !ce);
  chk_done_noskip: assert property (res && !stat.skip |=>
    stat.done && !stat.busy) else $error("no skip end late");
  chk_skip_flush: assert property (res && stat.skip |=>
    stat.flush && stat.no_operation) else $error("skip without flush");
  chk_skip_two: assert property (res && stat.skip
    && req.next_words == 2'h2
    |=> stat.no_operation [*8] ##1 stat.done) else $error("two word skip");
  chk_skip_three: assert property (res && stat.skip
    && req.next_words == 2'h3
    |=> stat.no_operation [*8] ##1 stat.no_operation [*4] ##1 stat.done)
    else $error("three word skip");
  chk_access_bank: assert property (mem.rd_en && !req.instr[8]
    && !(req.ext_en && lo) |-> mem.addr == (lo ? {6'h00, f} : {6'h3f, f}))
    else $error("access bank address");
  chk_bank_reg: assert property (mem.rd_en && req.instr[8] |->
    mem.addr == {req.bank_select_register, f}) else $error("bank address");
  chk_indexed_addr: assert property (mem.rd_en && !req.instr[8]
    && req.ext_en && lo |-> mem.addr == req.index_base + {6'h00, f})
    else $error("indexed address");
  chk_equal_skip: assert property (res && op == 7'h31 |->
    stat.skip == (rdata == req.working_register)) else $error("equal skip");
  chk_greater_skip: assert property (res && op == 7'h32 |->
    stat.skip == (rdata > req.working_register)) else $error("greater skip");
endmodule : csk_monitor

bind csk_exec csk_monitor u_mon (.clk(clk), .rst(rst), .ce(ce),
  .start(start), .req(req), .rdata(rdata), .mem(mem), .stat(stat),
  .q_phase(q_phase));

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import csk_pkg::*;
  logic clk = 0;
  logic rst = 1;
  logic ce = 1;
  logic start = 0;
  csk_req_s req = '0;
  logic [7:0] rdata = 8'h00;
  csk_mem_s mem;
  csk_stat_s stat;
  logic [1:0] q_phase;
  int failures = 0;
  int num_checks = 0;
  always #5 clk = ~clk;
  csk_exec u_dut (.clk(clk), .rst(rst), .ce(ce), .start(start), .req(req),
    .rdata(rdata), .mem(mem), .stat(stat), .q_phase(q_phase));
  task automatic check(input logic [13:0] seen, input logic [13:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %0t %h %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done
  // one compare, issued back to back with the previous one
  task automatic op(input logic [6:0] c, input logic a, input logic [7:0] f,
    input logic x, input logic [7:0] d, input logic [1:0] w,
    input logic [13:0] ea, input logic sk);
    int n;
    logic [13:0] ad;
    logic fl;
    req = '{{c, a, f}, 8'h80, 6'h2a, x, 14'h1200, w};
    rdata = d;
    start = 1;
    n = 0;
    ad = '1;
    fl = 0;
    do
    begin
      @(negedge clk);
      start = 0;
      n++;
      if (mem.rd_en === 1'b1)
        ad = mem.addr;
      if (stat.flush === 1'b1)
        fl = 1;
    end
    while (stat.done !== 1'b1 && n < 40);
    if (n >= 40)
    begin
      failures++;
      test_done();
    end
    check(14'(n), sk ? 14'(5 + 4 * (w == 0 ? 1 : w))
      : 14'h5);
    check(ad, ea);
    check({12'h0, fl, stat.skip}, {12'h0, sk, sk});
  endtask : op
  task automatic t_equal;
    op(7'h31, 1, 8'h10, 0, 8'h7f, 1, 14'h2a10, 0);
    op(7'h31, 1, 8'hff, 0, 8'h80, 1, 14'h2aff, 1);
  endtask : t_equal
  task automatic t_greater;
    op(7'h32, 1, 8'h10, 0, 8'h80, 1, 14'h2a10, 0);
    op(7'h32, 1, 8'h10, 0, 8'h81, 2, 14'h2a10, 1);
    op(7'h32, 1, 8'h10, 0, 8'hff, 3, 14'h2a10, 1);
  endtask : t_greater
  task automatic t_bank;
    op(7'h31, 0, 8'h5f, 0, 8'h00, 1, 14'h005f, 0);
    op(7'h31, 0, 8'h60, 0, 8'h00, 1, 14'h3f60, 0);
    op(7'h31, 0, 8'h5f, 1, 8'h00, 1, 14'h125f, 0);
    op(7'h31, 0, 8'h60, 1, 8'h00, 1, 14'h3f60, 0);
    op(7'h31, 1, 8'h05, 1, 8'h00, 1, 14'h2a05, 0);
  endtask : t_bank
  // ce low stalls a compare mid read; outputs hold, count resumes after
  task automatic t_freeze;
    int n;
    req = '{{7'h31, 1'b1, 8'h20}, 8'h80, 6'h2a, 1'b0, 14'h1200, 2'h1};
    rdata = 8'h7f;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    @(negedge clk);
    ce = 1'b0;
    repeat (3) @(negedge clk);
    check({11'h000, mem.rd_en, q_phase}, 14'h0005);
    check({12'h000, stat.busy, stat.done}, 14'h0002);
    check(mem.addr, 14'h2a20);
    ce = 1'b1;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (stat.done !== 1'b1 && n < 40);
    if (n >= 40)
    begin
      failures++;
      test_done();
    end
    check(14'(n), 14'h0003);
    check({13'h0000, stat.skip}, 14'h0000);
  endtask : t_freeze
  // reset in the middle of the inserted no_operation cycles
  task automatic t_reset;
    req = '{{7'h32, 1'b0, 8'h30}, 8'h10, 6'h2a, 1'b0, 14'h1200, 2'h3};
    rdata = 8'h11;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (5) @(negedge clk);
    check({13'h0000, stat.no_operation}, 14'h0001);
    rst = 1'b1;
    @(negedge clk);
    check(mem.addr, 14'h0000);
    check({6'h00, mem.rd_en, stat, q_phase}, 14'h0000);
    rst = 1'b0;
    @(negedge clk);
    check({6'h00, mem.rd_en, stat, q_phase}, 14'h0000);
    op(7'h32, 0, 8'h30, 0, 8'h81, 3, 14'h0030, 1);
  endtask : t_reset
  initial
  begin
    repeat (3) @(negedge clk);
    rst = 0;
    @(negedge clk);
    t_equal();
    t_greater();
    t_bank();
    t_freeze();
    t_reset();
    test_done();
  end
endmodule : tb_top
